// [plb_path.sv]
/*
 * PMA data-path selection: normal path with 66-bit gearbox, fast one-lane
 * bypass, direct loopback (PCS tx to PCS rx) and reverse loopback
 * (serializer rx to serializer tx). One clock, the system reference clock.
 * Assumes configuration inputs are quasi-static and from another domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "plb_cfg.svh"
// Overview of operation
// - Direct loopback, only with RS-FEC or in fast one-lane mode, feeds every PCS transmit word into PCS receive.
// - Direct loopback still feeds serializer, drops serializer receive data.
// - Reverse loopback retransmits every serializer receive word.
// - Reverse loopback still feeds PCS receive and drops PCS transmit data.
// - One loopback selection covers all lanes together.
// - Both loops run on the one reference clock, no crossing storage.
// - Without RS-FEC and outside fast one-lane mode, 66-bit blocks are geared to 40 or 80 bits.
// - Without RS-FEC, PCS receive takes 40-bit words, or 32-bit words in fast one-lane mode.
// - Fast one-lane mode sends PCS data straight out, no gearboxes.
// - Fast one-lane mode only with a 32-bit serializer width.
// - Fast-mode loopback works but at 32/40 of line rate.
module plb_path import plb_pkg::*; #(
    parameter int LANES = `PLB_LANES,
    parameter int SER_W = `PLB_SER_W,
    parameter int PCS_W = `PLB_PCS_BLK
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfg_direct_lb,
    input wire logic cfg_reverse_lb,
    input wire logic cfg_rsfec,
    input wire logic cfg_fast_lane,
    input wire logic cfg_ser_w32,
    input wire logic cfg_ser_wide,
    input wire logic pcs_tx_valid,
    input wire logic [LANES*SER_W-1:0] pcs_tx_data,
    output logic pcs_tx_ready,
    output logic pcs_rx_valid,
    output logic [LANES*SER_W-1:0] pcs_rx_data,
    input wire logic pcs_rx_ready,
    input wire logic ser_rx_valid,
    input wire logic [LANES*SER_W-1:0] ser_rx_data,
    output logic ser_rx_ready,
    output logic ser_tx_valid,
    output logic [LANES*SER_W-1:0] ser_tx_data,
    output logic direct_active,
    output logic reverse_active,
    output logic fast_active,
    output logic lb_conflict
);
    localparam int DW = LANES * SER_W;
    localparam int ACC_W = SER_W + PCS_W;

    typedef struct packed {
        logic [`PLB_CFG_BITS-1:0] cfg_meta;
        logic [`PLB_CFG_BITS-1:0] cfg;
        plb_mode_t mode;
        logic fast;
        logic conflict;
        logic [2:0] pace;
        logic [7:0] fill;
        logic [LANES-1:0][ACC_W-1:0] acc;
        logic [DW-1:0] tx_data;
        logic tx_valid;
    } plb_state_t;

    plb_state_t st;
    plb_state_t next_st;
    logic rst_meta_b;
    logic rst_sync_b;
    logic fec;
    logic fast_ok;
    logic gear;
    logic [7:0] ow;
    logic [7:0] tx_w;
    logic [7:0] rx_w;
    logic pace_ok;
    logic emit;
    logic [7:0] fill_left;
    logic room;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [DW-1:0] buf_in_data;
    logic [`PLB_CFG_BITS-1:0] cfg_in;

    // Keep the low n bits of every lane, clear the rest
    function automatic logic [DW-1:0] lane_mask(input logic [DW-1:0] d,
                                                input logic [7:0] n);
        logic [DW-1:0] r;
        r = '0;
        for (int l = 0; l < LANES; l++) begin
            for (int b = 0; b < SER_W; b++) begin
                if (b < int'(n)) begin
                    r[l*SER_W+b] = d[l*SER_W+b];
                end
            end
        end
        return r;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // Configuration word gathered from the pins
    always_comb begin
        cfg_in = '0;
        cfg_in[`PLB_CFG_DIRECT] = cfg_direct_lb;
        cfg_in[`PLB_CFG_REVERSE] = cfg_reverse_lb;
        cfg_in[`PLB_CFG_RSFEC] = cfg_rsfec;
        cfg_in[`PLB_CFG_FAST] = cfg_fast_lane;
        cfg_in[`PLB_CFG_W32] = cfg_ser_w32;
        cfg_in[`PLB_CFG_WIDE] = cfg_ser_wide;
    end

    // Mode decode and lane widths
    assign fec = st.cfg[`PLB_CFG_RSFEC];
    assign fast_ok = st.cfg[`PLB_CFG_FAST] && st.cfg[`PLB_CFG_W32]
                     && !fec;
    assign gear = !fec && !st.fast;
    assign ow = st.cfg[`PLB_CFG_WIDE] ? 8'(`PLB_W_WIDE) : 8'(`PLB_W_NARROW);
    assign tx_w = st.fast ? 8'(`PLB_W_FAST) : ow;
    assign rx_w = st.fast ? 8'(`PLB_W_FAST)
                : (fec ? ow : 8'(`PLB_W_NARROW));
    // Fast loopback drops one slot in five
    assign pace_ok = !(st.fast && (st.mode != PLB_NORMAL)
                       && (st.pace == 3'(`PLB_PACE_NUM)));

    // Gearbox fill after this cycle's emission
    assign emit = gear && (st.fill >= ow);
    assign fill_left = emit ? (st.fill - ow) : st.fill;
    assign room = (fill_left + 8'(PCS_W)) <= 8'(ACC_W);

    // Handshakes and receive-buffer source
    always_comb begin
        buf_in_valid = 1'b0;
        buf_in_data = lane_mask(ser_rx_data, rx_w);
        pcs_tx_ready = 1'b1;
        ser_rx_ready = buf_in_ready;
        case (st.mode)
            PLB_DIRECT: begin
                buf_in_valid = pcs_tx_valid && pace_ok;
                buf_in_data = lane_mask(pcs_tx_data, tx_w);
                pcs_tx_ready = buf_in_ready && pace_ok;
                ser_rx_ready = 1'b1;
            end
            PLB_REVERSE: begin
                buf_in_valid = ser_rx_valid && pace_ok;
                ser_rx_ready = buf_in_ready && pace_ok;
                pcs_tx_ready = 1'b1;
            end
            PLB_NORMAL: begin
                buf_in_valid = ser_rx_valid;
                pcs_tx_ready = gear ? room : 1'b1;
            end
            default: begin
                buf_in_valid = 1'b0;
            end
        endcase
    end

    // Next state: config sync, mode, pacing, gearbox, transmit word
    always_comb begin
        next_st = st;
        next_st.cfg_meta = cfg_in;
        next_st.cfg = st.cfg_meta;
        next_st.fast = fast_ok;
        next_st.conflict = st.cfg[`PLB_CFG_DIRECT]
                           && st.cfg[`PLB_CFG_REVERSE];
        // One mode for all lanes together
        if (next_st.conflict) begin
            next_st.mode = PLB_NORMAL;
        end else if (st.cfg[`PLB_CFG_DIRECT] && (fec || fast_ok)) begin
            next_st.mode = PLB_DIRECT;
        end else if (st.cfg[`PLB_CFG_REVERSE]) begin
            next_st.mode = PLB_REVERSE;
        end else begin
            next_st.mode = PLB_NORMAL;
        end
        // Pacing counter, 0 .. DEN-1
        if (st.pace >= 3'(`PLB_PACE_DEN - 1)) begin
            next_st.pace = 3'h0;
        end else begin
            next_st.pace = st.pace + 3'h1;
        end
        next_st.tx_valid = 1'b0;
        case (st.mode)
            PLB_DIRECT: begin
                next_st.fill = 8'h00;
                next_st.acc = '0; // Stale bits would corrupt later blocks
                if (pcs_tx_valid && pcs_tx_ready) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data = lane_mask(pcs_tx_data, tx_w);
                end
            end
            PLB_REVERSE: begin
                next_st.fill = 8'h00;
                next_st.acc = '0;
                if (ser_rx_valid && ser_rx_ready) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data = lane_mask(ser_rx_data, tx_w);
                end
            end
            default: begin
                if (!gear) begin
                    // RS-FEC or fast lane: word passes straight through
                    next_st.fill = 8'h00;
                    next_st.acc = '0;
                    if (pcs_tx_valid) begin
                        next_st.tx_valid = 1'b1;
                        next_st.tx_data = lane_mask(pcs_tx_data, tx_w);
                    end
                end else begin
                    // 66-bit blocks into 40/80-bit words
                    for (int l = 0; l < LANES; l++) begin
                        next_st.tx_data[l*SER_W +: SER_W] =
                            st.acc[l][SER_W-1:0];
                        next_st.acc[l] = emit ? (st.acc[l] >> ow)
                                              : st.acc[l];
                        if (pcs_tx_valid && room) begin
                            next_st.acc[l] = next_st.acc[l]
                                | (ACC_W'(pcs_tx_data[l*SER_W +: PCS_W])
                                   << fill_left);
                        end
                    end
                    next_st.tx_data = lane_mask(next_st.tx_data, ow);
                    next_st.tx_valid = emit;
                    next_st.fill = (pcs_tx_valid && room)
                        ? fill_left + 8'(PCS_W) : fill_left;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= '0;
            st.cfg_meta <= `PLB_CFG_RESET;
            st.cfg <= `PLB_CFG_RESET;
            st.mode <= PLB_NORMAL;
        end else begin
            st <= next_st;
        end
    end

    // Receive buffer toward the PCS, same clock throughout
    plb_buf #(.W(DW)) u_rx_buf (
        .clk(clk),
        .rst_b(rst_sync_b),
        .in_valid(buf_in_valid),
        .in_data(buf_in_data),
        .in_ready(buf_in_ready),
        .out_valid(pcs_rx_valid),
        .out_data(pcs_rx_data),
        .out_ready(pcs_rx_ready)
    );

    // Outputs from state
    assign ser_tx_valid = st.tx_valid;
    assign ser_tx_data = st.tx_data;
    assign direct_active = (st.mode == PLB_DIRECT);
    assign reverse_active = (st.mode == PLB_REVERSE);
    assign fast_active = st.fast;
    assign lb_conflict = st.conflict;

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_sync_b);
    a_direct_to_rx: assert property (
        direct_active && pcs_tx_valid && pcs_tx_ready |->
        buf_in_valid && buf_in_data == lane_mask(pcs_tx_data, tx_w))
        else $error("direct loop word not fed to receive");
    a_direct_tx_kept: assert property (
        direct_active && pcs_tx_valid && pcs_tx_ready |=>
        ser_tx_valid && ser_tx_data == $past(buf_in_data))
        else $error("direct loop lost serializer transmit");
    a_direct_rx_drop: assert property (
        direct_active |-> ser_rx_ready)
        else $error("serializer data not discarded");
    a_reverse_retx: assert property (
        reverse_active && ser_rx_valid && ser_rx_ready |=>
        ser_tx_valid && ser_tx_data == lane_mask($past(ser_rx_data),
                                                 $past(tx_w)))
        else $error("reverse loop word not retransmitted");
    a_reverse_pcs: assert property (
        reverse_active |-> pcs_tx_ready
        && (buf_in_valid == (ser_rx_valid && pace_ok)))
        else $error("reverse loop receive path wrong");
    a_mode_onehot: assert property (
        $onehot(st.mode))
        else $error("mode not one-hot");
    a_rx_latency: assert property (
        buf_in_valid && buf_in_ready && !pcs_rx_valid |=> pcs_rx_valid)
        else $error("receive word delayed");
    a_gear_emit: assert property (
        direct_active == 1'b0 && reverse_active == 1'b0 && emit |=>
        ser_tx_valid)
        else $error("gearbox word not sent");
    a_rx_narrow: assert property (
        !fec && !st.fast |->
        buf_in_data == lane_mask(buf_in_data, 8'(`PLB_W_NARROW)))
        else $error("receive word wider than 40 bits");
    a_fast_w32: assert property (
        fast_active |-> $past(st.cfg[`PLB_CFG_W32]) && !$past(fec))
        else $error("fast lane without 32-bit width");
    a_fast_pace: assert property (
        fast_active && !$stable(st.mode) == 1'b0 && !pace_ok |->
        !buf_in_valid ##1 pace_ok)
        else $error("fast loop pacing broken");
    a_both_normal: assert property (
        st.cfg[`PLB_CFG_DIRECT] && st.cfg[`PLB_CFG_REVERSE] |=>
        st.mode == PLB_NORMAL)
        else $error("conflicting loopbacks formed a loop");
    c_direct: cover property (direct_active && pcs_rx_valid);
    c_reverse: cover property (reverse_active && ser_tx_valid);
    c_gear: cover property (emit ##1 emit);
endmodule
`default_nettype wire

// [plb_cfg.svh]
/*
 * Constants of the loopback and low-latency path: bit positions of the
 * configuration word, reset values, data widths and the pacing ratio.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef PLB_CFG_SVH
`define PLB_CFG_SVH

// Configuration word bit positions
`define PLB_CFG_DIRECT 0
`define PLB_CFG_REVERSE 1
`define PLB_CFG_RSFEC 2
`define PLB_CFG_FAST 3
`define PLB_CFG_W32 4
`define PLB_CFG_WIDE 5
`define PLB_CFG_BITS 6
`define PLB_CFG_RESET 6'h00

// Lane count and widths
`define PLB_LANES 8
`define PLB_SER_W 80
`define PLB_PCS_BLK 66
`define PLB_W_WIDE 80
`define PLB_W_NARROW 40
`define PLB_W_FAST 32

// Fast-lane loopback pacing, 32/40 of the line rate = 4 words in 5
`define PLB_PACE_NUM 4
`define PLB_PACE_DEN 5

`endif

// [plb_pkg.sv]
/*
 * Types shared by the loopback path: the data-path mode enumeration.
 * Assumes plb_cfg.svh is available on the include path.
 */
package plb_pkg;
    // Data-path mode, one-hot
    typedef enum logic [2:0] {
        PLB_NORMAL = 3'b001,
        PLB_DIRECT = 3'b010,
        PLB_REVERSE = 3'b100
    } plb_mode_t;
endpackage

// [plb_buf.sv]
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and a reset already synchronised by the instantiator.
 */
`timescale 1ns/10ps
`default_nettype none
module plb_buf import plb_pkg::*; #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } plb_buf_state_t;

    plb_buf_state_t st;
    plb_buf_state_t next_st;
    logic push;
    logic pop;

    // Handshakes and head word
    assign in_ready = (st.cnt != 2'h2);
    assign out_valid = (st.cnt != 2'h0);
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Write, read and occupancy update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = ~st.wp;
        end
        if (pop) begin
            next_st.rp = ~st.rp;
        end
        case ({push, pop})
            2'b10: next_st.cnt = st.cnt + 2'h1;
            2'b01: next_st.cnt = st.cnt - 2'h1;
            default: next_st.cnt = st.cnt;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// [plb_pcs_sink.sv]
/*
 * Far-side model: PCS receive sink with a prompt, slow or stalled ready,
 * and a serializer transmit capture that never stalls.
 * Assumes one clock shared with the path and a bench that reads queues.
 */
`timescale 1ns/10ps
`default_nettype none
`include "plb_cfg.svh"
module plb_pcs_sink #(
    parameter int DW = `PLB_LANES*`PLB_SER_W
) (
    input wire logic clk,
    input wire logic stall,
    input wire logic slow,
    input wire logic pcs_rx_valid,
    input wire logic [DW-1:0] pcs_rx_data,
    output logic pcs_rx_ready,
    input wire logic ser_tx_valid,
    input wire logic [DW-1:0] ser_tx_data
);
    logic [DW-1:0] rxq[$];
    logic [DW-1:0] txq[$];
    logic [1:0] ph = 2'h0;
    // Ready pattern, words taken on the edge where ready is high
    always @(posedge clk) begin
        if (pcs_rx_valid === 1'b1 && pcs_rx_ready) rxq.push_back(pcs_rx_data);
        ph <= ph + 2'h1;
        pcs_rx_ready <= !stall && (!slow || ph == 2'h0);
    end
    // Serializer side runs at the same rate both ways
    always @(posedge clk) begin
        if (ser_tx_valid === 1'b1) txq.push_back(ser_tx_data);
    end
endmodule
`default_nettype wire

// [plb_path_tb.sv]
/*
 * Self-checking bench for the loopback path: reset, direct, reverse,
 * conflict, refusal, buffer stall, fast one-lane pacing and gearbox.
 * Assumes the far-side model plb_pcs_sink and default path parameters.
 */
`timescale 1ns/10ps
`default_nettype none
`include "plb_cfg.svh"
module plb_path_tb;
    localparam int SW = `PLB_SER_W;
    localparam int DW = `PLB_LANES*SW;
    logic clk = 1'b0, rst_b = 1'b0, stall = 1'b0, slow = 1'b0;
    logic c_dir = 1'b0, c_rev = 1'b0, c_fec = 1'b0;
    logic c_fast = 1'b0, c_w32 = 1'b0, c_wide = 1'b0;
    logic ptv = 1'b0, srv = 1'b0, prr, ptr, srr, stv;
    logic dact, ract, fact, conf, prv;
    logic [DW-1:0] ptd = '0, srd = '0, prd, std;
    int n_errors = 0, checks_done = 0, cyc = 0;
    plb_path dut_u (.clk(clk), .rst_b(rst_b), .cfg_direct_lb(c_dir),
        .cfg_reverse_lb(c_rev), .cfg_rsfec(c_fec), .cfg_fast_lane(c_fast),
        .cfg_ser_w32(c_w32), .cfg_ser_wide(c_wide), .pcs_tx_valid(ptv),
        .pcs_tx_data(ptd), .pcs_tx_ready(ptr), .pcs_rx_valid(prv),
        .pcs_rx_data(prd), .pcs_rx_ready(prr), .ser_rx_valid(srv),
        .ser_rx_data(srd), .ser_rx_ready(srr), .ser_tx_valid(stv),
        .ser_tx_data(std), .direct_active(dact), .reverse_active(ract),
        .fast_active(fact), .lb_conflict(conf));
    plb_pcs_sink sink_u (.clk(clk), .stall(stall), .slow(slow),
        .pcs_rx_valid(prv), .pcs_rx_data(prd), .pcs_rx_ready(prr),
        .ser_tx_valid(stv), .ser_tx_data(std));
    // Clock and cycle count
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // Lane-distinct pattern and per-lane width mask
    function automatic logic [DW-1:0] pat(input logic [7:0] k);
        logic [DW-1:0] r;
        for (int l = 0; l < `PLB_LANES; l++)
            r[l*SW +: SW] = {10{k ^ 8'(l*17)}};
        return r;
    endfunction
    // Gearbox word k of two 66-bit blocks per lane, LSB first, 40 wide
    function automatic logic [DW-1:0] gw(input logic [DW-1:0] a,
                                         input logic [DW-1:0] b, input int k);
        logic [2*`PLB_PCS_BLK-1:0] s;
        logic [DW-1:0] r;
        r = '0;
        for (int l = 0; l < `PLB_LANES; l++) begin
            s = {b[l*SW +: `PLB_PCS_BLK], a[l*SW +: `PLB_PCS_BLK]};
            r[l*SW +: `PLB_W_NARROW] = s[k*`PLB_W_NARROW +: `PLB_W_NARROW];
        end
        return r;
    endfunction
    function automatic logic [DW-1:0] msk(input logic [DW-1:0] d, input int w);
        logic [DW-1:0] r;
        r = '0;
        for (int l = 0; l < `PLB_LANES; l++)
            for (int b = 0; b < w; b++) r[l*SW+b] = d[l*SW+b];
        return r;
    endfunction
    task automatic chk_bit(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic chk_dat(input logic [DW-1:0] got, input logic [DW-1:0] exp,
                           input string m);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic chk_num(input int got, input int lo, input int hi,
                           input string m);
        checks_done++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[FAIL] %0t %s got %0d", $time, m, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Mode pins change only while idle, then settle
    task automatic set_cfg(input logic [5:0] c);
        {c_wide, c_w32, c_fast, c_fec, c_rev, c_dir} = c;
        sink_u.rxq.delete();
        step(6);
        sink_u.txq.delete();
    endtask
    // Hold word until taken on an edge with ready high
    task automatic send_pcs(input logic [DW-1:0] d);
        logic tk;
        ptv = 1'b1;
        ptd = d;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk) tk = ptr;
            step(1);
            if (tk) return;
        end
        chk_bit(1'b0, 1'b1, "pcs transmit never taken");
    endtask
    task automatic send_ser(input logic [DW-1:0] d);
        logic tk;
        srv = 1'b1;
        srd = d;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk) tk = srr;
            step(1);
            if (tk) return;
        end
        chk_bit(1'b0, 1'b1, "serializer receive never taken");
    endtask
    // Released data lines show the inverse of the last word
    task automatic idle();
        ptv = 1'b0;
        srv = 1'b0;
        ptd = ~ptd;
        srd = ~srd;
        step(6);
    endtask
    task automatic t_reset();
        chk_bit(dact | ract | fact | conf, 1'b0, "status after reset");
        chk_bit(prv | stv, 1'b0, "valid after reset");
        $display("test reset done");
    endtask
    task automatic t_direct();
        set_cfg(6'b100101);
        chk_bit(dact, 1'b1, "direct not active");
        send_pcs(pat(8'h01));
        idle();
        send_ser(pat(8'h02));
        idle();
        chk_num(sink_u.rxq.size(), 1, 1, "direct loop count");
        chk_dat(sink_u.rxq[0], pat(8'h01), "direct loop word");
        chk_num(sink_u.txq.size(), 1, 1, "direct tx count");
        chk_dat(sink_u.txq[0], pat(8'h01), "direct tx word");
        $display("test direct done");
    endtask
    task automatic t_reverse();
        set_cfg(6'b100110);
        chk_bit(ract, 1'b1, "reverse not active");
        send_ser(pat(8'h03));
        idle();
        send_pcs(pat(8'h04));
        idle();
        chk_num(sink_u.txq.size(), 1, 1, "reverse tx count");
        chk_dat(sink_u.txq[0], pat(8'h03), "reverse tx word");
        chk_num(sink_u.rxq.size(), 1, 1, "reverse rx count");
        chk_dat(sink_u.rxq[0], pat(8'h03), "reverse rx word");
        $display("test reverse done");
    endtask
    task automatic t_conflict();
        set_cfg(6'b100111);
        chk_bit(conf, 1'b1, "conflict flag");
        chk_bit(dact | ract, 1'b0, "loop formed on conflict");
        send_pcs(pat(8'h05));
        idle();
        chk_num(sink_u.rxq.size(), 0, 0, "looped on conflict");
        set_cfg(6'b000001);
        chk_bit(dact, 1'b0, "direct without fec");
        $display("test conflict done");
    endtask
    task automatic t_buffer();
        set_cfg(6'b000010);
        stall = 1'b1;
        slow = 1'b1;
        send_ser(pat(8'h06));
        send_ser(pat(8'h07));
        srd = pat(8'h08);
        repeat (4) @(negedge clk) chk_bit(srr, 1'b0, "ready when full");
        #5 stall = 1'b0;
        send_ser(pat(8'h08));
        idle();
        step(10);
        slow = 1'b0;
        chk_num(sink_u.rxq.size(), 3, 3, "buffered count");
        for (int i = 0; i < 3; i++)
            chk_dat(sink_u.rxq[i], msk(pat(8'(6+i)), 40), "buf word");
        chk_bit(prv, 1'b0, "buffer not empty");
        $display("test buffer done");
    endtask
    task automatic t_fast();
        int c0;
        set_cfg(6'b011001);
        chk_bit(fact & dact, 1'b1, "fast direct not active");
        c0 = cyc;
        for (int i = 0; i < 8; i++) send_pcs(pat(8'(16+i)));
        chk_num(cyc - c0, 9, 10, "fast pacing cycles");
        idle();
        chk_num(sink_u.rxq.size(), 8, 8, "fast loop count");
        chk_dat(sink_u.rxq[7], msk(pat(8'h17), 32), "fast loop word");
        chk_dat(sink_u.txq[0], msk(pat(8'h10), 32), "fast tx word");
        set_cfg(6'b001001);
        chk_bit(fact | dact, 1'b0, "fast without 32 bit");
        $display("test fast done");
    endtask
    // Two 66-bit blocks through the gearbox give three 40-bit words
    task automatic t_gear();
        logic [DW-1:0] a;
        logic [DW-1:0] b;
        a = pat(8'h21);
        b = pat(8'h42);
        set_cfg(6'b000000);
        send_pcs(a);
        send_pcs(b);
        idle();
        chk_num(sink_u.txq.size(), 3, 3, "gearbox word count");
        for (int k = 0; k < 3; k++)
            chk_dat(sink_u.txq[k], gw(a, b, k), "gear word");
        chk_num(sink_u.rxq.size(), 0, 0, "gearbox looped");
        $display("test gear done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        step(10);
        rst_b = 1'b1;
        step(6);
        t_reset();
        t_direct();
        t_reverse();
        t_conflict();
        t_buffer();
        t_fast();
        t_gear();
        test_done();
    end
    // Watchdog
    initial begin
        #(8 * 20000);
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
